// ===== cit_pkg.sv
// Purpose: Shared types and constants for the instruction timing decoder
// Assumes: One core clock cycle equals one clk_sys period
// Notes: Byte lengths and cycle counts are per opcode, not per instruction class
package cit_pkg;

  // Encoded instruction lengths in bytes
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  // Core clock cycles per instruction
  localparam logic [3:0] CYC1 = 4'h1;
  localparam logic [3:0] CYC2 = 4'h2;
  localparam logic [3:0] CYC3 = 4'h3;
  localparam logic [3:0] CYC4 = 4'h4;
  localparam logic [3:0] CYC9 = 4'h9;

  // Longest count that still counts as a fast instruction
  localparam logic [3:0] FAST_CYC_MAX = 4'h2;

  // Statistics counter width
  localparam int STAT_W = 16;

  // Instruction classes
  typedef enum logic [2:0] {
    CL_ARITH,
    CL_LOGIC,
    CL_XFER,
    CL_BOOL,
    CL_BRANCH,
    CL_MISC
  } cit_class_t;

  // Decoded timing of one instruction
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    cit_class_t cls;
    logic illegal;
  } cit_info_t;

  // Retirement statistics
  typedef struct packed {
    logic [STAT_W-1:0] retired;
    logic [STAT_W-1:0] fast;
    logic [STAT_W-1:0] cycles;
  } cit_stats_t;

endpackage

// ===== cit_timing_decoder.sv
// Purpose: Decode opcode length and cycle count, pace execution accordingly
// Assumes: Opcode input is synchronous to clk_sys, one opcode per handshake
// Notes: A new opcode is taken only when opReady is high
`timescale 1ns/1ps
`default_nettype none

module cit_timing_decoder
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Opcode offer
  input wire logic opValid,
  input wire logic [7:0] opcode,
  output var logic opReady,
  // Decoded timing of the taken opcode
  output var logic infoValid,
  output var cit_pkg::cit_info_t info,
  // Completion and statistics
  output var logic busy,
  output var logic done,
  output var cit_pkg::cit_stats_t stats
);
  import cit_pkg::*;

  // Build one decode entry
  // Illegal starts clear; only the unassigned codes raise it afterwards
  function automatic cit_info_t mk(input logic [1:0] l, input logic [3:0] c,
                                   input cit_class_t k);
    cit_info_t r;
    r.len = l;
    r.cyc = c;
    r.cls = k;
    r.illegal = 1'b0;
    return r;
  endfunction

  // Class of a register, indirect or direct source column by row
  // Rows share their operand columns, so one helper names the class for all of them
  function automatic cit_class_t rowClass(input logic [3:0] row);
    cit_class_t k;
    case (row)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h9: k = CL_ARITH;
      4'h4, 4'h5, 4'h6: k = CL_LOGIC;
      4'hb, 4'hd: k = CL_BRANCH;
      default: k = CL_XFER;
    endcase
    return k;
  endfunction

  // Full opcode decode into length, cycles and class
  // The low nibble is tested first because the operand column fixes the
  // byte count for most rows; the irregular columns fall back to an exact
  // match on the whole opcode, which costs more logic but stays readable.
  function automatic cit_info_t decode(input logic [7:0] op);
    cit_info_t d;
    logic [3:0] row;
    logic [3:0] col;
    row = op[7:4];
    col = op[3:0];
    d = mk(LEN1, CYC1, CL_MISC);
    // Absolute jumps and calls own this column in every row
    if (col == 4'h1)
    begin
      d = mk(LEN2, CYC3, CL_BRANCH);
    end
    else if (col[3])
    begin
      // Working register column
      case (row)
        4'h7, 4'h8, 4'ha: d = mk(LEN2, CYC2, CL_XFER);
        4'hb: d = mk(LEN3, CYC4, CL_BRANCH);
        4'hd: d = mk(LEN2, CYC3, CL_BRANCH);
        default: d = mk(LEN1, CYC1, rowClass(row));
      endcase
    end
    else if (col[3:1] == 3'h3)
    begin
      // Register-pointed memory column
      case (row)
        4'h7, 4'h8, 4'ha: d = mk(LEN2, CYC2, CL_XFER);
        4'hb: d = mk(LEN3, CYC4, CL_BRANCH);
        4'hd: d = mk(LEN1, CYC2, CL_XFER);
        default: d = mk(LEN1, CYC2, rowClass(row));
      endcase
    end
    else if (col == 4'h5)
    begin
      // Direct byte column
      case (row)
        4'h7, 4'h8: d = mk(LEN3, CYC3, CL_XFER);
        4'hb: d = mk(LEN3, CYC4, CL_BRANCH);
        4'hd: d = mk(LEN3, CYC4, CL_BRANCH);
        4'ha:
        begin
          d = mk(LEN1, CYC1, CL_MISC);
          d.illegal = 1'b1; // Unassigned code, paced like a no-op
        end
        default: d = mk(LEN2, CYC2, rowClass(row));
      endcase
    end
    else if (col == 4'h4)
    begin
      // Accumulator and immediate column
      // Rows 8 and a are the long multiply and divide
      case (row)
        4'h0, 4'h1: d = mk(LEN1, CYC1, CL_ARITH);
        4'h2, 4'h3, 4'h9: d = mk(LEN2, CYC2, CL_ARITH);
        4'h4, 4'h5, 4'h6: d = mk(LEN2, CYC2, CL_LOGIC);
        4'h7: d = mk(LEN2, CYC2, CL_XFER);
        4'h8, 4'ha: d = mk(LEN1, CYC9, CL_ARITH);
        4'hb: d = mk(LEN3, CYC4, CL_BRANCH);
        4'hd: d = mk(LEN1, CYC2, CL_ARITH);
        default: d = mk(LEN1, CYC1, CL_LOGIC);
      endcase
    end
    else
    begin
      // Columns 0, 2 and 3 are irregular
      case (op)
        8'h00: d = mk(LEN1, CYC1, CL_MISC);
        8'h02, 8'h12: d = mk(LEN3, CYC4, CL_BRANCH);
        8'h03, 8'h13, 8'h23, 8'h33: d = mk(LEN1, CYC1, CL_LOGIC);
        8'h10, 8'h20, 8'h30: d = mk(LEN3, CYC4, CL_BRANCH);
        8'h22, 8'h32: d = mk(LEN1, CYC4, CL_BRANCH);
        8'h40, 8'h50, 8'h80: d = mk(LEN2, CYC3, CL_BRANCH);
        8'h60, 8'h70: d = mk(LEN2, CYC3, CL_BRANCH);
        8'h42, 8'h52, 8'h62: d = mk(LEN2, CYC2, CL_LOGIC);
        8'h43, 8'h53, 8'h63: d = mk(LEN3, CYC3, CL_LOGIC);
        8'h72, 8'h82, 8'h92, 8'ha0: d = mk(LEN2, CYC2, CL_BOOL);
        8'ha2, 8'hb0, 8'hb2, 8'hc2: d = mk(LEN2, CYC2, CL_BOOL);
        8'hd2: d = mk(LEN2, CYC2, CL_BOOL);
        8'hb3, 8'hc3, 8'hd3: d = mk(LEN1, CYC1, CL_BOOL);
        8'h73: d = mk(LEN1, CYC3, CL_BRANCH);
        8'h83, 8'h93: d = mk(LEN1, CYC4, CL_XFER);
        8'h90: d = mk(LEN3, CYC3, CL_XFER);
        8'ha3: d = mk(LEN1, CYC3, CL_ARITH);
        8'hc0, 8'hd0: d = mk(LEN2, CYC2, CL_XFER);
        8'he0, 8'he2, 8'he3: d = mk(LEN1, CYC4, CL_XFER);
        8'hf0, 8'hf2, 8'hf3: d = mk(LEN1, CYC4, CL_XFER);
        default:
        begin
          d = mk(LEN1, CYC1, CL_MISC);
          d.illegal = 1'b1;
        end
      endcase
    end
    return d;
  endfunction

  // Pacing holds the core for the decoded count; no fetch is modelled,
  // so operand bytes never appear on the opcode port.
  // Execution pacing state
  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } cit_state_t;

  cit_state_t state;
  cit_state_t next_state;
  cit_info_t dec;
  logic take;
  logic [3:0] remain;
  logic [3:0] next_remain;
  logic finish;

  // Combinational decode of the offered opcode
  always_comb
  begin
    dec = decode(opcode);
  end

  // Taking only on a registered ready keeps the decode off the ready path,
  // at the cost of one idle edge after reset.
  // Handshake; ready is registered so it must be qualified here
  assign take = opValid && opReady;

  // Next pacing values; a taken opcode reloads the remaining count
  always_comb
  begin
    next_state = state;
    next_remain = remain;
    finish = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (take)
        begin
          next_remain = dec.cyc - CYC1;
          finish = (dec.cyc == CYC1);
          next_state = finish ? ST_IDLE : ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        next_remain = remain - CYC1;
        finish = (remain == CYC1);
        if (finish)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_remain = 4'h0;
      end
    endcase
  end

  // State and cycle counter; one count per core clock cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      remain <= 4'h0;
    end
    else
    begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  // Both flags follow the next state so that they never lag the counter
  // Ready and busy flags; one-cycle opcodes keep ready high back to back
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      opReady <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      opReady <= (next_state == ST_IDLE);
      busy <= (next_state == ST_EXEC);
    end
  end

  // Info is held until the next take so a slow reader still sees it
  // Decoded timing captured on each taken opcode
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      infoValid <= 1'b0;
      info <= '0;
    end
    else
    begin
      infoValid <= take;
      if (take)
      begin
        info <= dec;
      end
    end
  end

  // Done is registered so that it rises together with ready
  // Completion pulse in the cycle after the last execution edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= finish;
    end
  end

  // The fast test needs the count of the retiring instruction; a one-cycle
  // op retires in its take cycle, before this register can hold it.
  // Cycle count of the instruction currently in flight, for the statistics
  logic [3:0] curCyc;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      curCyc <= 4'h0;
    end
    else if (take)
    begin
      curCyc <= dec.cyc;
    end
  end

  // Small counters trade range for area: a reader must sample often enough
  // that no counter advances by a full wrap between two samples.
  // Retirement statistics; counters wrap, software sees rates by sampling
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stats <= '0;
    end
    else
    begin
      if (state == ST_EXEC || take)
      begin
        stats.cycles <= stats.cycles + 1'b1;
      end
      if (finish)
      begin
        stats.retired <= stats.retired + 1'b1;
        if ((take ? dec.cyc : curCyc) <= FAST_CYC_MAX)
        begin
          stats.fast <= stats.fast + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== cit_timing_monitor.sv
// Purpose: Port-level timing checks for the instruction timing decoder
// Assumes: One core clock cycle per clk_sys period
// Notes: Done spacing is tied to the cycle count shown with infoValid
`timescale 1ns/1ps
`default_nettype none

module cit_timing_monitor
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Opcode offer
  input wire logic opValid,
  input wire logic [7:0] opcode,
  input wire logic opReady,
  // Decoded info
  input wire logic infoValid,
  input wire cit_pkg::cit_info_t info,
  // Completion and statistics
  input wire logic busy,
  input wire logic done,
  input wire cit_pkg::cit_stats_t stats
);
  import cit_pkg::*;
  // One domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_take_gives_info: assert property (opValid && opReady |=> infoValid)
    else $error("no info after a take");
  a_info_needs_take: assert property (infoValid |-> $past(opValid && opReady))
    else $error("info without a take");
  a_busy_blocks_take: assert property (busy |-> !opReady ##1 !infoValid)
    else $error("ready while busy");
  a_one_cycle_done: assert property (infoValid && info.cyc == CYC1 |-> done && opReady)
    else $error("one cycle op not done at once");
  a_two_cycle_done: assert property (infoValid && info.cyc == CYC2 |-> busy && !done ##1 done)
    else $error("two cycle op timing");
  a_three_cycle_done: assert property (infoValid && info.cyc == CYC3 |=> !done ##1 done)
    else $error("three cycle op timing");
  a_four_cycle_done: assert property (infoValid && info.cyc == CYC4 |=> !done[*2] ##1 done && opReady)
    else $error("four cycle op timing");
  a_nine_cycle_done: assert property (infoValid && info.cyc == CYC9 |=> !done[*7] ##1 done)
    else $error("nine cycle op timing");
endmodule

bind cit_timing_decoder cit_timing_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .opValid(opValid),
  .opcode(opcode), .opReady(opReady), .infoValid(infoValid), .info(info), .busy(busy), .done(done),
  .stats(stats));

`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the instruction timing decoder
// Assumes: Opcodes follow the standard 8-bit encoding
// Notes: Table entries pack opcode, byte count and cycle count
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b,m) begin checks++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end

module tb;
  import cit_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic opValid = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic opReady, infoValid, busy, done, rdy;
  cit_info_t info;
  cit_stats_t stats, s0;
  int fails = 0, checks = 0, nRet = 0, nFast = 0, nCyc = 0;
  logic [31:0] seed = 32'h77e18a52;
  // Expectation of the instruction last taken, handed to the falling-edge checker
  int takes = 0, seen = 0, age = -1, expN = 0;
  logic [15:0] expE = 16'h0;
  logic expIll = 1'b0;
  // Opcode, bytes, cycles
  logic [15:0] tbl [$] = {16'h2811, 16'h9b11, 16'h2612, 16'h5712, 16'h2522, 16'h6522,
    16'h9422, 16'h2422, 16'h5333, 16'h4333, 16'h6333, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
    16'h9314, 16'h8314, 16'he014, 16'he214, 16'hf014, 16'hf314, 16'hc022, 16'hd022,
    16'hd612, 16'h8533, 16'h7533, 16'h9033, 16'hc222, 16'hd222, 16'hb222, 16'h8222,
    16'hb022, 16'h7222, 16'ha022, 16'ha222, 16'h9222, 16'h7313, 16'h1123, 16'h0123,
    16'h8023, 16'h4023, 16'h5023, 16'h6023, 16'h7023, 16'h0234, 16'h1234, 16'h2034,
    16'h3034, 16'h1034, 16'hb534, 16'hb434, 16'hb834, 16'hb634, 16'hd823, 16'hd534,
    16'ha419, 16'h8419, 16'h2214, 16'h3214, 16'ha313, 16'hd412, 16'h0011};

  cit_timing_decoder u_dut (.clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opcode(opcode),
    .opReady(opReady), .infoValid(infoValid), .info(info), .busy(busy), .done(done), .stats(stats));

  // 200 MHz core clock
  always #2.5 clk_sys = ~clk_sys;

  // Ready as the next rising edge will see it, free of edge races
  always @(negedge clk_sys) rdy = opReady;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Outputs of the instruction in flight, compared where they are settled
  always @(negedge clk_sys)
  begin
    if (takes != seen)
    begin
      seen = takes;
      age = 0;
    end
    if (age == 0)
    begin
      `CHK(infoValid, 1'b1, "info pulse")
      `CHK(info.len, expE[5:4], "length")
      `CHK(info.illegal, expIll, "illegal flag")
    end
    else if (age > 0)
    begin
      `CHK(infoValid, 1'b0, "refused offer")
    end
    if (age >= 0)
    begin
      `CHK(info.cyc, expE[3:0], "cycles")
      `CHK(done, age == expN - 1, "done timing")
      `CHK(busy, age < expN - 1, "busy level")
      `CHK(opReady, age == expN - 1, "ready level")
      age = (age < expN - 1) ? age + 1 : -1;
    end
  end

  // Offer one entry at a rising edge; while an op of three or more cycles is busy, junk is offered on a random bit and must be refused
  task automatic issue(input logic [15:0] e, input logic ill);
    int n;
    int w;
    n = e[3:0];
    w = 0;
    opValid <= 1'b1;
    opcode <= e[15:8];
    do
    begin
      @(posedge clk_sys);
      w++;
    end
    while (!rdy && w < 20);
    if (!rdy)
    begin
      fails++;
      results();
    end
    // Take edge: the checker looks at the outputs from the next falling edge on
    expE = e;
    expIll = ill;
    expN = n;
    takes++;
    nRet++;
    nCyc += n;
    nFast += (n <= 2);
    if (n > 1)
    begin
      seed = xs(seed);
      opValid <= (n > 2) & seed[0];
      opcode <= seed[15:8];
      for (int k = 1; k < n; k++)
      begin
        @(posedge clk_sys);
        if (k == n - 2)
          opValid <= 1'b0;
      end
    end
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (tbl[i])
      issue(tbl[i], 1'b0);
    issue(16'ha511, 1'b1);
    $display("test table done");
    opValid <= 1'b0;
    repeat (2) @(negedge clk_sys);
    s0 = stats;
    @(posedge clk_sys);
    nRet = 0;
    nCyc = 0;
    nFast = 0;
    // Random picks, some back to back, some after idle gaps
    repeat (200)
    begin
      seed = xs(seed);
      if (seed[3:2] != 2'h0)
      begin
        opValid <= 1'b0;
        repeat (seed[3:2]) @(posedge clk_sys);
      end
      issue(tbl[seed % tbl.size()], 1'b0);
    end
    $display("test random done");
    opValid <= 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK(stats.retired, s0.retired + 16'(nRet), "retired count")
    `CHK(stats.fast, s0.fast + 16'(nFast), "fast count")
    `CHK(stats.cycles, s0.cycles + 16'(nCyc), "cycle count")
    $display("test stats done");
    results();
  end
endmodule

`default_nettype wire
